// [core/disk_cmd_pkg.sv]
// Package of offsets, fields, opcodes and reset values for the command executor
package disk_cmd_pkg;
    // Task-file I/O addresses
    localparam logic [9:0] ADDR_FEATURE_FAULT    = 10'h1_F1;
    localparam logic [9:0] ADDR_SECTOR_COUNT     = 10'h1_F2;
    localparam logic [9:0] ADDR_SECTOR_NUMBER    = 10'h1_F3;
    localparam logic [9:0] ADDR_CYLINDER_LOW     = 10'h1_F4;
    localparam logic [9:0] ADDR_CYLINDER_HIGH    = 10'h1_F5;
    localparam logic [9:0] ADDR_DEVICE_HEAD      = 10'h1_F6;
    localparam logic [9:0] ADDR_OPCODE_CONDITION = 10'h1_F7;
    // Opcodes with the lowest bit masked off
    localparam logic [7:0] OPC_VERIFY    = 8'h40;
    localparam logic [7:0] OPC_WRITE     = 8'h30;
    localparam logic [7:0] OPC_LSB_MASK  = 8'hFE;
    // Device/head field positions
    localparam int HEADSEL_LBA_BIT   = 6;
    localparam int HEADSEL_DRIVE_BIT = 4;
    // Condition bit positions
    localparam int COND_BUSY_BIT  = 7;
    localparam int COND_READY_BIT = 6;
    localparam int COND_SEEKD_BIT = 4;
    localparam int COND_ERR_BIT   = 0;
    // Fault code for a refused opcode
    localparam logic [7:0] FAULT_ABORTED = 8'h04;
    // Reset values
    localparam logic [7:0] RST_FEATURE_FAULT = 8'h00;
    localparam logic [7:0] RST_SECTOR_COUNT  = 8'h01;
    localparam logic [7:0] RST_SECTOR_NUMBER = 8'h01;
    localparam logic [7:0] RST_CYLINDER      = 8'h00;
    localparam logic [7:0] RST_DEVICE_HEAD   = 8'h00;
    // Largest request, taken when the count register reads zero
    localparam logic [8:0] MAX_SECTORS = 9'h100;
    // Command engine states, Gray coded along the usual path
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_SEEK  = 3'b001,
        S_ISSUE = 3'b011,
        S_WAIT  = 3'b010,
        S_DONE  = 3'b110
    } exec_state_e;
endpackage

// [core/addr_step_if.sv]
// Interface carrying the current sector address and its successor
`timescale 1ns/1ps
interface addr_step_if;
    logic       lba_mode;    // Logical block addressing selected
    logic [7:0] sec;         // Current sector index / address bits 7:0
    logic [7:0] cyl_lo;      // Current cylinder low / address bits 15:8
    logic [7:0] cyl_hi;      // Current cylinder high / address bits 23:16
    logic [3:0] head;        // Current head / address bits 27:24
    logic [7:0] nxt_sec;     // Next sector index
    logic [7:0] nxt_cyl_lo;  // Next cylinder low
    logic [7:0] nxt_cyl_hi;  // Next cylinder high
    logic [3:0] nxt_head;    // Next head
    modport user (output lba_mode, sec, cyl_lo, cyl_hi, head,
                  input nxt_sec, nxt_cyl_lo, nxt_cyl_hi, nxt_head);
    modport step (input lba_mode, sec, cyl_lo, cyl_hi, head,
                  output nxt_sec, nxt_cyl_lo, nxt_cyl_hi, nxt_head);
endinterface // addr_step_if

// [core/addr_step.sv]
// Successor of a sector address in geometry or logical block addressing
`timescale 1ns/1ps
module addr_step #(
    parameter logic [7:0] SECTORS_PER_TRACK = 8'h3F,
    parameter logic [3:0] HEADS             = 4'hF
) (
    // Address pair
    addr_step_if.step a
);
    logic [27:0] lba_nxt;  // Logical address plus one
    logic [15:0] cyl_nxt;  // Cylinder plus one

    assign lba_nxt = {a.head, a.cyl_hi, a.cyl_lo, a.sec} + 28'h000_0001;
    assign cyl_nxt = {a.cyl_hi, a.cyl_lo} + 16'h0001;

    // Logical mode counts straight; geometry mode wraps sector, then head
    always_comb begin
        if (a.lba_mode) begin
            {a.nxt_head, a.nxt_cyl_hi, a.nxt_cyl_lo, a.nxt_sec} = lba_nxt;
        end else if (a.sec < SECTORS_PER_TRACK) begin
            a.nxt_sec  = a.sec + 8'h01;
            a.nxt_head = a.head;
            {a.nxt_cyl_hi, a.nxt_cyl_lo} = {a.cyl_hi, a.cyl_lo};
        end else if (a.head < HEADS) begin
            a.nxt_sec  = 8'h01;
            a.nxt_head = a.head + 4'h1;
            {a.nxt_cyl_hi, a.nxt_cyl_lo} = {a.cyl_hi, a.cyl_lo};
        end else begin
            a.nxt_sec  = 8'h01;
            a.nxt_head = 4'h0;
            {a.nxt_cyl_hi, a.nxt_cyl_lo} = cyl_nxt;
        end
    end
endmodule // addr_step

// [core/disk_cmd_exec.sv]
// Verify and sector-write command executor behind the task-file registers
// Functional notes
// (RULE1) Opcodes 40h/41h verify; no data to host
// (RULE2) Verify done: drop busy, raise interrupt
// (RULE3) Verify ok leaves last verified address
// (RULE4) Verify stops at the failing sector
// (RULE5) Verify error: count holds unverified sectors
// (RULE6) Error: address registers hold failing sector
// (RULE7) Opcodes 30h/31h write; low bit ignored
// (RULE8) Write accepts up to 256 sectors
// (RULE9) Start at given address, then consecutive sectors
// (RULE10) Seek implicitly before writing off-track sector; no seek is made in logical mode
// (RULE11) Sector gets buffered data plus CRC/ECC
// (RULE12) Write ok leaves last written address
// (RULE13) Write stops at failing sector
// (RULE14) Count zero on success, remainder on error
// (RULE15) Host sets mode, drive, head in device/head
// (RULE16) Device/head keeps mode and drive bits
// (RULE17) Host may read registers after error
// (RULE18) Count zero means 256 sectors
// (RULE19) Host writes parameters before the opcode
`timescale 1ns/1ps
module disk_cmd_exec #(
    parameter logic [7:0] SECTORS_PER_TRACK = 8'h3F,
    parameter logic [3:0] HEADS             = 4'hF
) (
    // Clock, reset, enable
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        ce,
    // Task-file register port
    input  wire logic [9:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic        io_rd,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    output logic             intrq,
    // Positioner
    output logic             seek_req,
    output logic      [15:0] seek_cyl,
    input  wire logic        seek_done,
    input  wire logic [15:0] head_cyl,
    // Sector engine
    input  wire logic        buf_ready,
    output logic             med_req,
    output logic             med_write,
    output logic             med_ecc_en,
    output logic             med_lba_mode,
    output logic      [27:0] med_addr,
    input  wire logic        med_done,
    input  wire logic        med_err,
    input  wire logic [7:0]  med_err_code
);

    // Task-file contents seen by the host
    logic        [7:0]  sec_count_q;  // Sector tally, counts down while busy
    logic        [7:0]  sec_num_q;    // First sector index, then current one
    logic        [7:0]  cyl_lo_q;     // Cylinder low / address bits 15:8
    logic        [7:0]  cyl_hi_q;     // Cylinder high / address bits 23:16
    logic        [7:0]  dev_head_q;   // Mode, drive, head / address 27:24
    logic        [7:0]  fault_q;      // Fault information of last command

    // Command engine
    disk_cmd_pkg::exec_state_e state_q;  // Engine state
    logic               busy_q;       // Command in progress
    logic               err_q;        // Last command ended on an error
    logic               is_write_q;   // Current command writes the medium
    logic        [8:0]  rem_q;        // Sectors not yet processed

    // Decoded host accesses and helpers
    logic               host_wr;      // Write strobe, only while idle
    logic               host_rd;      // Read strobe
    logic               cmd_wr;       // Opcode byte written
    logic               opc_verify;   // Opcode selects verify
    logic               opc_write;    // Opcode selects sector write
    logic               opc_valid;    // Opcode is one of the two
    logic        [15:0] cur_cyl;      // Cylinder of the current sector
    logic               lba_sel;      // Logical addressing selected
    logic               on_track;     // Head already on that cylinder, or logical mode
    logic               issue_go;     // Sector request leaves this cycle
    logic               sector_end;   // Sector engine answered
    logic               last_sector;  // Only one sector left
    logic        [7:0]  cond_byte;    // Condition byte for the host

    // Successor address, computed outside the engine
    addr_step_if step_bus ();

    // Host strobes; writes are refused while a command runs
    assign host_wr = ce && io_wr && !busy_q;
    assign host_rd = ce && io_rd;
    assign cmd_wr  = host_wr && (io_addr == disk_cmd_pkg::ADDR_OPCODE_CONDITION);

    // Opcode decode with the lowest bit ignored
    assign opc_verify = (io_wdata & disk_cmd_pkg::OPC_LSB_MASK)
                        == disk_cmd_pkg::OPC_VERIFY;  // [RULE1]
    assign opc_write  = (io_wdata & disk_cmd_pkg::OPC_LSB_MASK)
                        == disk_cmd_pkg::OPC_WRITE;   // [RULE7]
    assign opc_valid  = opc_verify || opc_write;

    // Position check against the positioner's cylinder
    assign cur_cyl  = {cyl_hi_q, cyl_lo_q};
    assign lba_sel  = dev_head_q[disk_cmd_pkg::HEADSEL_LBA_BIT];
    assign on_track = lba_sel || (head_cyl == cur_cyl);  // [RULE10]

    // Engine events
    assign issue_go    = (state_q == disk_cmd_pkg::S_ISSUE) && (!is_write_q || buf_ready);
    assign sector_end  = (state_q == disk_cmd_pkg::S_WAIT) && med_done;
    assign last_sector = (rem_q == 9'h001);

    // Current address handed to the successor logic
    assign step_bus.lba_mode = lba_sel;
    assign step_bus.sec      = sec_num_q;
    assign step_bus.cyl_lo   = cyl_lo_q;
    assign step_bus.cyl_hi   = cyl_hi_q;
    assign step_bus.head     = dev_head_q[3:0];

    // Next sector in the chosen addressing mode
    addr_step #(
        .SECTORS_PER_TRACK (SECTORS_PER_TRACK),
        .HEADS             (HEADS)
    ) addr_step_inst (
        .a (step_bus)
    );  // [RULE9]

    // Condition byte; ready is always shown, seek done while no seek runs
    always_comb begin
        cond_byte = 8'h00;
        cond_byte[disk_cmd_pkg::COND_BUSY_BIT]  = busy_q;
        cond_byte[disk_cmd_pkg::COND_READY_BIT] = 1'b1;
        cond_byte[disk_cmd_pkg::COND_SEEKD_BIT] = !seek_req;
        cond_byte[disk_cmd_pkg::COND_ERR_BIT]   = err_q;
    end

    // Engine sequencing: position, issue, wait, then finish
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= disk_cmd_pkg::S_IDLE;
        end else if (ce) begin
            case (state_q)
                // Start only on a known opcode
                disk_cmd_pkg::S_IDLE: begin
                    if (cmd_wr && opc_valid) begin
                        state_q <= disk_cmd_pkg::S_SEEK;
                    end
                end
                // Leave once no seek runs and, in geometry mode, the head is on track
                disk_cmd_pkg::S_SEEK: begin
                    if (!seek_req && on_track) begin
                        state_q <= disk_cmd_pkg::S_ISSUE;  // [RULE10]
                    end
                end
                // Writes wait for buffered host data
                disk_cmd_pkg::S_ISSUE: begin
                    if (issue_go) begin
                        state_q <= disk_cmd_pkg::S_WAIT;
                    end
                end
                // Stop on error or after the last sector
                disk_cmd_pkg::S_WAIT: begin
                    if (med_done) begin
                        if (med_err || last_sector) begin
                            state_q <= disk_cmd_pkg::S_DONE;  // [RULE4] [RULE13]
                        end else begin
                            state_q <= disk_cmd_pkg::S_SEEK;
                        end
                    end
                end
                // One cycle to post completion
                disk_cmd_pkg::S_DONE: begin
                    state_q <= disk_cmd_pkg::S_IDLE;
                end
                default: begin
                    state_q <= disk_cmd_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Busy flag: set by a known opcode, dropped at completion
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            busy_q <= 1'b0;
        end else if (ce) begin
            if (cmd_wr && opc_valid) begin
                busy_q <= 1'b1;
            end else if (state_q == disk_cmd_pkg::S_DONE) begin
                busy_q <= 1'b0;  // [RULE2]
            end
        end
    end

    // Command kind latched at issue
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            is_write_q <= 1'b0;
        end else if (ce && cmd_wr) begin
            is_write_q <= opc_write;
        end
    end

    // Remaining sectors; a zero count asks for the maximum
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            rem_q <= 9'h000;
        end else if (ce) begin
            if (cmd_wr && opc_valid) begin
                if (sec_count_q == 8'h00) begin
                    rem_q <= disk_cmd_pkg::MAX_SECTORS;  // [RULE8] [RULE18]
                end else begin
                    rem_q <= {1'b0, sec_count_q};
                end
            end else if (sector_end && !med_err) begin
                rem_q <= rem_q - 9'h001;
            end
        end
    end

    // Error flag and fault byte; a refused opcode aborts at once
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            err_q   <= 1'b0;
            fault_q <= disk_cmd_pkg::RST_FEATURE_FAULT;
        end else if (ce) begin
            if (cmd_wr) begin
                err_q   <= !opc_valid;
                fault_q <= opc_valid ? 8'h00 : disk_cmd_pkg::FAULT_ABORTED;
            end else if (sector_end && med_err) begin
                err_q   <= 1'b1;
                fault_q <= med_err_code;
            end
        end
    end

    // Interrupt: cleared by a condition read or a new opcode; set wins
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            intrq <= 1'b0;
        end else if (ce) begin
            if (state_q == disk_cmd_pkg::S_DONE || (cmd_wr && !opc_valid)) begin
                intrq <= 1'b1;  // [RULE2]
            end else if (cmd_wr) begin
                intrq <= 1'b0;
            end else if (host_rd && io_addr == disk_cmd_pkg::ADDR_OPCODE_CONDITION) begin
                intrq <= 1'b0;
            end
        end
    end

    // Implied seek, held until the positioner answers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            seek_req <= 1'b0;
            seek_cyl <= 16'h0000;
        end else if (ce) begin
            if (state_q == disk_cmd_pkg::S_SEEK && !seek_req && !on_track) begin
                seek_req <= 1'b1;  // [RULE10]
                seek_cyl <= cur_cyl;
            end else if (seek_done) begin
                seek_req <= 1'b0;
            end
        end
    end

    // Sector request, held until the sector engine answers
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            med_req      <= 1'b0;
            med_write    <= 1'b0;
            med_ecc_en   <= 1'b0;
            med_lba_mode <= 1'b0;
            med_addr     <= 28'h000_0000;
        end else if (ce) begin
            if (issue_go) begin
                med_req      <= 1'b1;
                med_write    <= is_write_q;  // [RULE1]
                med_ecc_en   <= 1'b1;        // [RULE11]
                med_lba_mode <= lba_sel;
                med_addr     <= {dev_head_q[3:0], cyl_hi_q, cyl_lo_q, sec_num_q};
            end else if (sector_end) begin
                med_req <= 1'b0;
            end
        end
    end

    // Task file: host writes while idle, engine updates while busy
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            sec_count_q <= disk_cmd_pkg::RST_SECTOR_COUNT;
            sec_num_q   <= disk_cmd_pkg::RST_SECTOR_NUMBER;
            cyl_lo_q    <= disk_cmd_pkg::RST_CYLINDER;
            cyl_hi_q    <= disk_cmd_pkg::RST_CYLINDER;
            dev_head_q  <= disk_cmd_pkg::RST_DEVICE_HEAD;
        end else if (ce) begin
            if (host_wr) begin
                // Feature byte has no effect on these two commands
                case (io_addr)
                    disk_cmd_pkg::ADDR_SECTOR_COUNT:  sec_count_q <= io_wdata;
                    disk_cmd_pkg::ADDR_SECTOR_NUMBER: sec_num_q   <= io_wdata;
                    disk_cmd_pkg::ADDR_CYLINDER_LOW:  cyl_lo_q    <= io_wdata;
                    disk_cmd_pkg::ADDR_CYLINDER_HIGH: cyl_hi_q    <= io_wdata;
                    disk_cmd_pkg::ADDR_DEVICE_HEAD:   dev_head_q  <= io_wdata;  // [RULE15]
                    default: begin
                    end
                endcase
            end else if (sector_end) begin
                if (med_err) begin
                    // Address stays on the failing sector
                    sec_count_q <= rem_q[7:0];  // [RULE5] [RULE6] [RULE14]
                end else if (last_sector) begin
                    // Address stays on the last sector handled
                    sec_count_q <= 8'h00;  // [RULE3] [RULE12] [RULE14]
                end else begin
                    // Step on; mode and drive bits are kept
                    sec_count_q     <= rem_q[7:0] - 8'h01;
                    sec_num_q       <= step_bus.nxt_sec;  // [RULE9]
                    cyl_lo_q        <= step_bus.nxt_cyl_lo;
                    cyl_hi_q        <= step_bus.nxt_cyl_hi;
                    dev_head_q[3:0] <= step_bus.nxt_head;  // [RULE16]
                end
            end
        end
    end

    // Registered read data for the host
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            io_rdata <= 8'h00;
        end else if (host_rd) begin
            case (io_addr)
                disk_cmd_pkg::ADDR_FEATURE_FAULT:    io_rdata <= fault_q;
                disk_cmd_pkg::ADDR_SECTOR_COUNT:     io_rdata <= sec_count_q;
                disk_cmd_pkg::ADDR_SECTOR_NUMBER:    io_rdata <= sec_num_q;
                disk_cmd_pkg::ADDR_CYLINDER_LOW:     io_rdata <= cyl_lo_q;
                disk_cmd_pkg::ADDR_CYLINDER_HIGH:    io_rdata <= cyl_hi_q;
                disk_cmd_pkg::ADDR_DEVICE_HEAD:      io_rdata <= dev_head_q;
                disk_cmd_pkg::ADDR_OPCODE_CONDITION: io_rdata <= cond_byte;
                default:                             io_rdata <= 8'h00;
            endcase
        end
    end

    // Completion drops busy and raises the interrupt
    a_done_posts_status: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE2]
        (state_q == disk_cmd_pkg::S_DONE && ce) |=> (!busy_q && intrq))
        else $error("busy or interrupt wrong after completion");

    // Verify never writes the medium
    a_verify_no_write: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE1]
        (med_req && !is_write_q) |-> !med_write)
        else $error("verify request marked as write");

    // Geometry requests only leave with the head on track
    a_request_on_track: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE10]
        ($rose(med_req) && !med_lba_mode) |-> (med_addr[23:8] == head_cyl))
        else $error("sector request while off track");

    // A failing sector ends the command
    a_stop_on_error: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE13]
        (sector_end && med_err && ce) |=> (state_q == disk_cmd_pkg::S_DONE && !med_req))
        else $error("engine went on after a failing sector");

    // Clean completion leaves a zero tally
    a_count_zero_ok: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE14]
        (state_q == disk_cmd_pkg::S_DONE && !err_q) |-> (sec_count_q == 8'h00))
        else $error("tally not zero after clean completion");

    // Mode and drive bits stay put while busy
    a_mode_bits_kept: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE16]
        (busy_q && $past(busy_q)) |-> $stable(dev_head_q[7:4]))
        else $error("mode or drive bits changed during a command");

    // A zero tally asks for the largest request
    a_zero_is_max: assert property (@(posedge sys_clk) disable iff (!nrst) // [RULE18]
        (cmd_wr && opc_valid && sec_count_q == 8'h00) |=>
        (rem_q == disk_cmd_pkg::MAX_SECTORS))
        else $error("zero tally not taken as largest request");

    // Main scenarios
    c_write_done: cover property (@(posedge sys_clk) disable iff (!nrst)
        state_q == disk_cmd_pkg::S_DONE && is_write_q && !err_q);
    c_verify_error: cover property (@(posedge sys_clk) disable iff (!nrst)
        sector_end && med_err && !is_write_q);
    c_implied_seek: cover property (@(posedge sys_clk) disable iff (!nrst)
        seek_req && seek_done);
endmodule // disk_cmd_exec

// [bench/disk_media_model.sv]
// Positioner and sector engine model facing the executor
`timescale 1ns/1ps
module disk_media_model (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    // Positioner
    input  wire logic        seek_req,
    input  wire logic [15:0] seek_cyl,
    output logic             seek_done,
    output logic      [15:0] head_cyl,
    // Sector engine with one failing address
    input  wire logic        med_req,
    input  wire logic [27:0] med_addr,
    input  wire logic [27:0] bad_addr,
    output logic             med_done,
    output logic             med_err
);
    // Answer each request one cycle later
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            {seek_done, med_done, med_err, head_cyl} <= '0;
        end else begin
            seek_done <= seek_req && !seek_done;
            if (seek_req) head_cyl <= seek_cyl;
            med_done <= med_req && !med_done;
            med_err <= med_req && !med_done && med_addr == bad_addr;
        end
    end
endmodule // disk_media_model

// [bench/disk_verify_write_sector_cmds_bench.sv]
// Bench for write and verify commands
`timescale 1ns/1ps
module disk_verify_write_sector_cmds_bench;
    logic        sys_clk = 0, nrst = 0, io_wr = 0, io_rd = 0;
    logic        intrq, seek_req, seek_done, med_req, med_done, med_err;
    logic [9:0]  io_addr = 0;
    logic [7:0]  io_wdata = 0, io_rdata;
    logic [15:0] seek_cyl, head_cyl;
    logic [27:0] med_addr, bad_addr = 28'hFFF_FFFF;
    int          miscompares = 0, compares = 0;
    always #10 sys_clk = ~sys_clk;
    disk_cmd_exec disk_cmd_exec_inst (.sys_clk, .nrst, .ce(1'b1), .io_addr, .io_wr,
        .io_rd, .io_wdata, .io_rdata, .intrq, .seek_req, .seek_cyl, .seek_done, .head_cyl,
        .buf_ready(1'b1), .med_req, .med_write(), .med_ecc_en(), .med_lba_mode(),
        .med_addr, .med_done, .med_err, .med_err_code(8'h10));
    disk_media_model disk_media_model_inst (.sys_clk, .nrst, .seek_req, .seek_cyl,
        .seek_done, .head_cyl, .med_req, .med_addr, .bad_addr, .med_done, .med_err);
    task automatic check(string s, logic [15:0] e, logic [15:0] g);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic wr(logic [9:0] a, logic [7:0] d);
        @(negedge sys_clk) {io_addr, io_wdata, io_wr} = {a, d, 1'b1};
        @(negedge sys_clk) io_wr = 0;
    endtask
    task automatic rd(logic [9:0] a, logic [7:0] e, logic [7:0] m = 8'hFF);
        @(negedge sys_clk) {io_addr, io_rd} = {a, 1'b1};
        @(negedge sys_clk) check($sformatf("reg %h", a), e & m, io_rdata & m);
        io_rd = 0;
    endtask
    // Load the task file, issue, wait for the interrupt, then read status
    task automatic cmd(logic [7:0] dh, sn, sc, cl, op);
        wr(10'h1_F6, dh);
        wr(10'h1_F3, sn);
        wr(10'h1_F2, sc);
        wr(10'h1_F4, cl);
        wr(10'h1_F5, 8'h00);
        wr(10'h1_F7, op);
        for (int i = 0; i < 3000 && intrq !== 1'b1; i++) @(negedge sys_clk);
        check("intrq", 16'h0001, {15'h0000, intrq});
        if (intrq !== 1'b1) complete_run();
        else rd(10'h1_F7, 8'h00, 8'h80);
    endtask
    task automatic complete_run();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge sys_clk);
        nrst = 1;
        cmd(8'h10, 8'h01, 8'h02, 8'h05, 8'h31);
        check("cylinder", 16'h0005, head_cyl);
        rd(10'h1_F3, 8'h02);
        rd(10'h1_F2, 8'h00);
        rd(10'h1_F6, 8'h10);
        bad_addr = 28'h000_0021;
        cmd(8'h50, 8'h20, 8'h03, 8'h00, 8'h40);
        rd(10'h1_F3, 8'h21);
        rd(10'h1_F2, 8'h02);
        rd(10'h1_F6, 8'h50);
        rd(10'h1_F7, 8'h01, 8'h01);
        rd(10'h1_F1, 8'h10);
        complete_run();
    end
endmodule // disk_verify_write_sector_cmds_bench
